// ---- dsw_host.v ----
// drive side host: status word fetch and status response block source
//
// Implementation choices: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "dsw_regs.vh"
module dsw_host #(
  parameter NBYTES = `DSW_BLOCK_BYTES
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // status transfer pins of the adapter
  output reg [1:0] status_select,
  output reg status_xfer_req,
  input wire [15:0] accumulator,
  input wire accumulator_valid,
  // control bus from the adapter sequencer
  input wire [7:0] ctrl_bus_code,
  input wire ctrl_bus_strobe,
  // response block stream to the adapter
  output wire [7:0] resp_byte,
  output wire resp_valid,
  input wire resp_ready,
  // drive event pulses for the unsolicited byte
  input wire [7:0] drive_event
);
  localparam X_IDLE = 2'h0;
  localparam X_REQ = 2'h1;
  localparam X_WAIT = 2'h2;

  // ahb address phase capture
  reg a_wr;
  reg [7:0] a_addr;
  wire a_take;
  reg [31:0] next_hrdata;

  // software registers
  reg [1:0] ctrl_sel;
  reg [5:0] fault_bits;
  reg [31:0] detail_lo;
  reg [31:0] detail_hi;
  reg [15:0] id_word;
  reg id_valid;
  reg [1:0] id_sel;
  reg [1:0] xstate;
  reg [7:0] last_code;
  reg [7:0] block_count;
  reg [7:0] ignored_count;
  reg [7:0] unsol_snap;

  wire go;
  wire [7:0] unsol_q;
  wire [7:0] unsol_clr;
  wire [7:0] exc_byte;
  wire [NBYTES*8-1:0] block;
  wire send_busy;
  wire send_done;
  wire read_status;
  wire [5:0] id_sector;
  wire [4:0] id_head;
  wire id_clean;
  wire id_read_protect;
  wire id_write_protect;
  wire [31:0] stat_word;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign a_take = hsel && hready && htrans[1];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_wr <= 1'b0;
      a_addr <= 8'h00;
    end else begin
      a_wr <= a_take && hwrite;
      a_addr <= haddr[7:0];
    end
  end

  // register writes in the data phase
  assign go = a_wr && (a_addr == `DSW_CTRL_OFF) && hwdata[`DSW_CTRL_GO_BIT];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_sel <= `DSW_CTRL_RST;
      fault_bits <= `DSW_FAULT_RST;
      detail_lo <= `DSW_DETAIL_RST;
      detail_hi <= `DSW_DETAIL_RST;
    end else if (a_wr) begin
      case (a_addr)
        `DSW_CTRL_OFF: begin
          ctrl_sel <= hwdata[`DSW_CTRL_SEL_MSB:`DSW_CTRL_SEL_LSB];
        end
        `DSW_FAULT_OFF: begin
          fault_bits <= hwdata[5:0];
        end
        `DSW_DETAIL_LO_OFF: begin
          detail_lo <= hwdata;
        end
        `DSW_DETAIL_HI_OFF: begin
          detail_hi <= hwdata;
        end
        default: begin
          detail_hi <= detail_hi;
        end
      endcase
    end
  end

  // status word fetch through the status select pins
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xstate <= X_IDLE;
      status_select <= `DSW_SEL_ENDING;
      status_xfer_req <= 1'b0;
      id_word <= 16'h0000;
      id_valid <= 1'b0;
      id_sel <= 2'h0;
    end else begin
      status_xfer_req <= 1'b0;
      case (xstate)
        X_IDLE: begin
          if (go) begin
            status_select <= hwdata[`DSW_CTRL_SEL_MSB:`DSW_CTRL_SEL_LSB];
            status_xfer_req <= 1'b1;
            id_valid <= 1'b0;
            xstate <= X_REQ;
          end
        end
        X_REQ: begin
          xstate <= X_WAIT;
          if (accumulator_valid) begin
            id_word <= accumulator;
            id_sel <= status_select;
            id_valid <= 1'b1;
            xstate <= X_IDLE;
          end
        end
        X_WAIT: begin
          if (accumulator_valid) begin
            id_word <= accumulator;
            id_sel <= status_select;
            id_valid <= 1'b1;
            xstate <= X_IDLE;
          end
        end
        default: begin
          xstate <= X_IDLE;
        end
      endcase
    end
  end

  // field view of a sector/head word
  assign id_sector = id_word[`DSW_SECTOR_MSB:`DSW_SECTOR_LSB];
  assign id_head = id_word[`DSW_HEAD_MSB:`DSW_HEAD_LSB];
  assign id_clean = ((id_word & (`DSW_ID_UNUSED_MASK | `DSW_ID_UNUSED_MASK2)) == 16'h0000);

  // protect flags, only meaningful for a sector/head word
  assign id_read_protect = id_word[`DSW_RP_BIT] && (id_sel == `DSW_SEL_SECTOR_HEAD);
  assign id_write_protect = id_word[`DSW_WP_BIT] && (id_sel == `DSW_SEL_SECTOR_HEAD);

  // unsolicited events, cleared once reported or by software
  assign unsol_clr = ({8{send_done}} & unsol_snap) |
    ({8{a_wr && (a_addr == `DSW_UNSOL_OFF)}} & hwdata[7:0]);
  dsw_event_latch #(
    .W(8),
    .KEEP(`DSW_UNSOL_KEEP)
  ) u_unsol (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(drive_event),
    .clr(unsol_clr),
    .q(unsol_q)
  );

  // exception byte 0
  assign exc_byte = {1'b0,
    (unsol_q != 8'h00),
    fault_bits};

  // block laid out with byte 0 in the low lane, sent first
  assign block = {detail_hi[15:0], detail_lo, unsol_q, exc_byte};

  assign read_status = ctrl_bus_strobe && (ctrl_bus_code == `DSW_CODE_READ_STATUS);

  dsw_block_sender #(
    .NBYTES(NBYTES)
  ) u_send (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(read_status && !send_busy),
    .block(block),
    .busy(send_busy),
    .done(send_done),
    .resp_byte(resp_byte),
    .resp_valid(resp_valid),
    .resp_ready(resp_ready)
  );

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_code <= 8'h00;
      block_count <= 8'h00;
      ignored_count <= 8'h00;
      unsol_snap <= 8'h00;
    end else begin
      if (ctrl_bus_strobe) begin
        last_code <= ctrl_bus_code;
      end
      if (read_status && !send_busy) begin
        unsol_snap <= unsol_q;
      end
      if (ctrl_bus_strobe && (!read_status || send_busy)) begin
        ignored_count <= ignored_count + 8'h01;
      end
      if (send_done) begin
        block_count <= block_count + 8'h01;
      end
    end
  end

  // status word: counts, last code, protect flags, busy flags
  assign stat_word = {ignored_count, block_count, last_code, 4'h0,
    id_write_protect, id_read_protect, send_busy, (xstate != X_IDLE)};

  // read data prepared in the address phase
  always @* begin
    next_hrdata = 32'h00000000;
    case (haddr[7:0])
      `DSW_CTRL_OFF: begin
        next_hrdata = {30'h0000000, ctrl_sel};
      end
      `DSW_IDWORD_OFF: begin
        next_hrdata = {id_clean, 1'b0, id_head, id_sector, id_sel, id_valid, id_word};
      end
      `DSW_FAULT_OFF: begin
        next_hrdata = {24'h000000, exc_byte};
      end
      `DSW_UNSOL_OFF: begin
        next_hrdata = {24'h000000, unsol_q};
      end
      `DSW_DETAIL_LO_OFF: begin
        next_hrdata = detail_lo;
      end
      `DSW_DETAIL_HI_OFF: begin
        next_hrdata = detail_hi;
      end
      `DSW_STAT_OFF: begin
        next_hrdata = stat_word;
      end
      default: begin
        next_hrdata = 32'h00000000;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (a_take && !hwrite) begin
      hrdata <= next_hrdata;
    end
  end
endmodule // dsw_host

// ---- dsw_regs.vh ----
// register map, field positions and codes for the drive status word host
`ifndef DSW_REGS_VH
`define DSW_REGS_VH
// register byte offsets
`define DSW_CTRL_OFF 8'h00
`define DSW_IDWORD_OFF 8'h04
`define DSW_FAULT_OFF 8'h08
`define DSW_UNSOL_OFF 8'h0C
`define DSW_DETAIL_LO_OFF 8'h10
`define DSW_DETAIL_HI_OFF 8'h14
`define DSW_STAT_OFF 8'h18
// reset values
`define DSW_CTRL_RST 2'h0
`define DSW_FAULT_RST 6'h00
`define DSW_DETAIL_RST 32'h00000000
// control register fields
`define DSW_CTRL_SEL_LSB 0
`define DSW_CTRL_SEL_MSB 1
`define DSW_CTRL_GO_BIT 8
// status select encodings
`define DSW_SEL_ENDING 2'h0
`define DSW_SEL_CYLINDER 2'h1
`define DSW_SEL_SECTOR_HEAD 2'h2
// identifier status word fields
`define DSW_SECTOR_LSB 0
`define DSW_SECTOR_MSB 5
`define DSW_HEAD_LSB 6
`define DSW_HEAD_MSB 10
`define DSW_RP_BIT 12
`define DSW_WP_BIT 13
`define DSW_ID_UNUSED_MASK 16'h8800
`define DSW_ID_UNUSED_MASK2 16'h4000
// exception byte 0 fields
`define DSW_EXC_UNSOL_BIT 6
`define DSW_EXC_RESP_BIT 7
// unsolicited byte 1 reserved bit mask (bit 3)
`define DSW_UNSOL_KEEP 8'hF7
// bus control code for read status
`define DSW_CODE_READ_STATUS 8'h44
// response block length in bytes
`define DSW_BLOCK_BYTES 8
`endif

// ---- dsw_event_latch.v ----
// sticky event bits, set wins over clear
`timescale 1ns/10ps
module dsw_event_latch #(
  parameter W = 8,
  parameter [W-1:0] KEEP = {W{1'b1}}
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // events
  input wire [W-1:0] set,
  input wire [W-1:0] clr,
  // state
  output wire [W-1:0] q
);
  reg [W-1:0] bits;
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          bits[i] <= 1'b0;
        end else if (KEEP[i]) begin
          bits[i] <= set[i] | (bits[i] & ~clr[i]);
        end else begin
          bits[i] <= 1'b0;
        end
      end
    end
  endgenerate
  assign q = bits;
endmodule // dsw_event_latch

// ---- dsw_block_sender.v ----
// sends a response block one byte at a time, byte 0 first
`timescale 1ns/10ps
module dsw_block_sender #(
  parameter NBYTES = 8
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // load
  input wire load,
  input wire [NBYTES*8-1:0] block,
  output wire busy,
  output wire done,
  // byte stream
  output reg [7:0] resp_byte,
  output wire resp_valid,
  input wire resp_ready
);
  localparam S_IDLE = 1'b0;
  localparam S_SEND = 1'b1;
  reg state;
  reg [NBYTES*8-1:0] shift;
  reg [7:0] left;
  wire take;
  assign take = (state == S_SEND) && resp_ready;
  assign resp_valid = (state == S_SEND);
  assign busy = (state == S_SEND);
  assign done = take && (left == 8'h01);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= S_IDLE;
      shift <= {NBYTES*8{1'b0}};
      left <= 8'h00;
      resp_byte <= 8'h00;
    end else begin
      case (state)
        S_IDLE: begin
          if (load) begin
            state <= S_SEND;
            resp_byte <= block[7:0];
            shift <= block >> 8;
            left <= NBYTES[7:0];
          end
        end
        S_SEND: begin
          if (take) begin
            resp_byte <= shift[7:0];
            shift <= shift >> 8;
            left <= left - 8'h01;
            if (left == 8'h01) begin
              state <= S_IDLE;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule // dsw_block_sender

// ---- dsw_host_props.sv ----
// assertions on the fetch and response block ports
`timescale 1ns/10ps
module dsw_host_props (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // status fetch
  input wire [1:0] status_select,
  input wire status_xfer_req,
  // control bus and block stream
  input wire [7:0] ctrl_bus_code,
  input wire ctrl_bus_strobe,
  input wire [7:0] resp_byte,
  input wire resp_valid,
  input wire resp_ready
);
  reg [3:0] takes;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // bytes taken in the current block
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      takes <= 4'h0;
    end else if (!resp_valid) begin
      takes <= 4'h0;
    end else if (resp_ready) begin
      takes <= takes + 4'h1;
    end
  end
  sequence s_go;
    ctrl_bus_strobe && !resp_valid;
  endsequence
  sequence s_stall;
    resp_valid && !resp_ready;
  endsequence
  AST_REQ_PULSE: assert property (status_xfer_req |=> !status_xfer_req)
    else $error("fetch request longer than one cycle");
  AST_SEL_MOVE: assert property ($changed(status_select) |-> $rose(status_xfer_req))
    else $error("select moved without a fetch");
  AST_SEL_CODE: assert property (status_xfer_req |-> status_select != 2'h3)
    else $error("undefined select code");
  AST_START: assert property (s_go ##0 (ctrl_bus_code == 8'h44) |=> resp_valid)
    else $error("read status code did not start a block");
  AST_IGNORE: assert property (s_go ##0 (ctrl_bus_code != 8'h44) |=> !resp_valid)
    else $error("other code started a block");
  AST_HOLD: assert property (s_stall |=> resp_valid && $stable(resp_byte))
    else $error("byte dropped while stalled");
  AST_FIRST: assert property ($rose(resp_valid) |-> !resp_byte[7])
    else $error("byte 0 top bit set");
  AST_EIGHT: assert property ($fell(resp_valid) |-> takes == 4'h8)
    else $error("block not eight bytes");
endmodule // dsw_host_props
bind dsw_host dsw_host_props dsw_host_props_i (.hclk(hclk), .hresetn(hresetn),
  .status_select(status_select), .status_xfer_req(status_xfer_req),
  .ctrl_bus_code(ctrl_bus_code), .ctrl_bus_strobe(ctrl_bus_strobe),
  .resp_byte(resp_byte), .resp_valid(resp_valid), .resp_ready(resp_ready));

// ---- dsw_adapter_model.sv ----
// far side model: adapter answering fetches, issuing codes, capturing blocks
`timescale 1ns/10ps
module dsw_adapter_model #(
  parameter [15:0] END_W = 16'hA5C3,
  parameter [15:0] CYL_W = 16'h0F1E,
  parameter [5:0] SECT = 6'h2B,
  parameter [4:0] HEAD = 5'h15,
  parameter [1:0] PROT = 2'h3
) (
  // clock, reset and pace
  input wire hclk,
  input wire hresetn,
  input wire slow,
  // status fetch
  input wire [1:0] status_select,
  input wire status_xfer_req,
  output reg [15:0] accumulator,
  output reg accumulator_valid,
  // control bus
  input wire code_go,
  input wire [7:0] code_in,
  output reg [7:0] ctrl_bus_code,
  output reg ctrl_bus_strobe,
  // block stream and capture
  input wire [7:0] resp_byte,
  input wire resp_valid,
  output reg resp_ready,
  output reg [63:0] cap_block,
  output reg [3:0] cap_cnt
);
  reg [1:0] sel;
  reg [2:0] dly;
  wire [15:0] word = sel[1] ? {2'h0, PROT, 1'b0, HEAD, SECT} : sel[0] ? CYL_W : END_W;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel <= 2'h0;
      dly <= 3'h0;
      accumulator <= 16'h0;
      accumulator_valid <= 1'b0;
      ctrl_bus_code <= 8'h0;
      ctrl_bus_strobe <= 1'b0;
      resp_ready <= 1'b0;
      cap_block <= 64'h0;
      cap_cnt <= 4'h0;
    end else begin
      ctrl_bus_strobe <= code_go;
      ctrl_bus_code <= code_go ? code_in : ~ctrl_bus_code;
      resp_ready <= !slow | !resp_ready;
      accumulator_valid <= 1'b0;
      accumulator <= ~accumulator;
      if (status_xfer_req) begin
        sel <= status_select;
        dly <= slow ? 3'h4 : 3'h1;
      end else if (dly != 3'h0) begin
        dly <= dly - 3'h1;
        accumulator_valid <= dly == 3'h1;
        if (dly == 3'h1) accumulator <= word;
      end
      if (resp_valid && resp_ready) begin
        cap_block[cap_cnt*8 +: 8] <= resp_byte;
        cap_cnt <= cap_cnt + 4'h1;
      end
    end
  end
endmodule // dsw_adapter_model

// ---- dsw_host_tb_top.sv ----
// testbench for the drive status word host
`timescale 1ns/10ps
module dsw_host_tb_top;
  reg hclk, hresetn, hsel, hwrite, slow, code_go;
  reg [31:0] haddr, hwdata, r;
  reg [1:0] htrans;
  reg [2:0] hsize;
  reg [7:0] drive_event, code_in;
  reg [15:0] ex [0:2];
  wire hreadyout, hresp, status_xfer_req, accumulator_valid, ctrl_bus_strobe;
  wire resp_valid, resp_ready;
  wire [31:0] hrdata;
  wire [1:0] status_select;
  wire [15:0] accumulator;
  wire [7:0] ctrl_bus_code, resp_byte;
  wire [63:0] cap_block;
  wire [3:0] cap_cnt;
  integer err_total, checks_done, i, n;
  dsw_host dsw_host_i (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .status_select(status_select),
    .status_xfer_req(status_xfer_req),
    .accumulator(accumulator),
    .accumulator_valid(accumulator_valid),
    .ctrl_bus_code(ctrl_bus_code),
    .ctrl_bus_strobe(ctrl_bus_strobe),
    .resp_byte(resp_byte),
    .resp_valid(resp_valid),
    .resp_ready(resp_ready),
    .drive_event(drive_event)
  );
  dsw_adapter_model dsw_adapter_model_i (
    .hclk(hclk),
    .hresetn(hresetn),
    .slow(slow),
    .status_select(status_select),
    .status_xfer_req(status_xfer_req),
    .accumulator(accumulator),
    .accumulator_valid(accumulator_valid),
    .code_go(code_go),
    .code_in(code_in),
    .ctrl_bus_code(ctrl_bus_code),
    .ctrl_bus_strobe(ctrl_bus_strobe),
    .resp_byte(resp_byte),
    .resp_valid(resp_valid),
    .resp_ready(resp_ready),
    .cap_block(cap_block),
    .cap_cnt(cap_cnt)
  );
  always #10 hclk = ~hclk;
  task chk(input [31:0] g, input [31:0] e);
    checks_done = checks_done + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task ahb(input w, input [7:0] a, input [31:0] d);
    hwrite <= w;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    r = hrdata;
  endtask
  task code(input [7:0] c);
    code_in <= c;
    code_go <= 1'b1;
    @(posedge hclk);
    code_go <= 1'b0;
    @(posedge hclk);
  endtask
  task complete_run;
    if (err_total == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    err_total = err_total + 1;
    complete_run;
  end
  initial begin
    {hclk, hresetn, hwrite, slow, code_go, haddr, hwdata, htrans} = 0;
    {drive_event, code_in, err_total, checks_done} = 0;
    hsel = 1'b1;
    hsize = 3'h2;
    ex[0] = 16'hA5C3;
    ex[1] = 16'h0F1E;
    ex[2] = {4'h3, 1'b0, 5'h15, 6'h2B};
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(0, 8'h00, 0);
    chk(r, 0);
    chk({30'h0, hreadyout, hresp}, 32'h2);
    ahb(0, 8'h40, 0);
    chk(r, 0);
    for (i = 0; i < 3; i = i + 1) begin
      slow <= i[0];
      ahb(1, 8'h00, {23'h0, 1'b1, 6'h0, i[1:0]});
      r = 32'h1;
      for (n = 0; n < 40 && r[0]; n = n + 1) ahb(0, 8'h18, 0);
      chk({31'h0, r[0]}, 0);
      ahb(0, 8'h04, 0);
      chk({16'h0, r[15:0]}, {16'h0, ex[i]});
      chk({29'h0, r[18:16]}, {29'h0, i[1:0], 1'b1});
      if (i == 2) chk({16'h0, r[31:16]}, {16'h0, 1'b1, 1'b0, 5'h15, 6'h2B, 3'h5});
    end
    drive_event <= 8'hFF;
    @(posedge hclk);
    drive_event <= 8'h00;
    ahb(0, 8'h0C, 0);
    chk(r, 32'hF7);
    ahb(1, 8'h08, 32'h15);
    ahb(0, 8'h08, 0);
    chk(r, 32'h55);
    ahb(1, 8'h08, 32'h2A);
    slow <= 1'b1;
    code(8'h55);
    code(8'h44);
    for (n = 0; n < 80 && cap_cnt != 4'h8; n = n + 1) @(posedge hclk);
    chk({28'h0, cap_cnt}, 32'h8);
    chk(cap_block[31:0], 32'h0000F76A);
    chk(cap_block[63:32], 0);
    ahb(0, 8'h0C, 0);
    chk(r, 0);
    ahb(0, 8'h08, 0);
    chk(r, 32'h2A);
    ahb(0, 8'h18, 0);
    chk(r, 32'h0101440C);
    complete_run;
  end
endmodule // dsw_host_tb_top
